/* File: hdl/icr_core.sv */
// indexed code read, computed jump and length-aware fetch core
`timescale 1ns/10ps
// Function
// - the pointer table read fetches code at acc plus pointer into acc.
// - the pc table read fetches code at acc plus pc into acc.
// - the pc used for the pc table read already points past that read.
// - the computed jump loads pc with acc plus pointer.
// - rotate left moves every acc bit one place up, msb wraps to bit 0.
// - the subroutine return is one byte long.
// - compare-and-branch is three bytes, absolute jump two bytes.
// - the long jump is three bytes at consecutive code locations.
// - the pointer is one 16-bit register of a high and a low byte.
module icr_core
   import icr_pkg::*;
(
   // clock and reset
   input  wire logic          core_clk,
   input  wire logic          rstn,
   // code memory
   output icr_code_req_t      code_req,
   input  icr_code_rsp_t      code_rsp,
   // architectural state
   output logic [7:0]         acc,
   output logic [15:0]        pc,
   output logic [7:0]         pointer_high_byte,
   output logic [7:0]         pointer_low_byte
);
   logic       rst_meta;
   logic       rst_sync;
   icr_state_t state;
   icr_state_t next_state;
   logic [7:0]  opcode;
   logic [7:0]  next_opcode;
   logic [7:0]  next_acc;
   logic [15:0] next_pc;
   logic [7:0]  next_pointer_high_byte;
   logic [7:0]  next_pointer_low_byte;
   icr_code_req_t next_code_req;
   logic [15:0] op_addr;
   logic [15:0] next_op_addr;
   logic [7:0]  opnd1;
   logic [7:0]  next_opnd1;

   // unsigned 8-bit offset added in 16 bits, carry out dropped
   function automatic logic [15:0] idx_sum(input logic [7:0] a,
                                           input logic [15:0] base);
      logic [16:0] s;
      s = {9'h000, a} + {1'b0, base};
      return s[15:0];
   endfunction

   // encoded length of an opcode, used to advance pc
   function automatic logic [15:0] op_len(input logic [7:0] op);
      logic [15:0] n;
      n = LEN_ONE;
      if (op == OP_CMP_BR || op == OP_LONG_JUMP || op == OP_PTR_LOAD) begin
         n = LEN_THREE;
      end else if (op[4:0] == OP_ABS_LOW) begin
         n = LEN_TWO;
      end
      return n;
   endfunction

   // reset release through two flops
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   // the pointer as one address
   logic [15:0] ptr;
   assign ptr = {pointer_high_byte, pointer_low_byte};

   // next-state logic; pc advances as each instruction byte is fetched
   always_comb begin
      next_state = state;
      next_opcode = opcode;
      next_acc = acc;
      next_pc = pc;
      next_pointer_high_byte = pointer_high_byte;
      next_pointer_low_byte = pointer_low_byte;
      next_code_req = '0;
      next_op_addr = op_addr;
      next_opnd1 = opnd1;
      case (state)
         ST_FETCH: begin
            next_code_req.req = 1'b1;
            next_code_req.addr = pc;
            next_op_addr = pc;
            next_pc = pc + LEN_ONE;
            next_state = ST_OPC;
         end
         ST_OPC: begin
            if (code_rsp.valid) begin
               next_opcode = code_rsp.data;
               next_state = ST_FETCH;
               if (op_len(code_rsp.data) != LEN_ONE) begin
                  // fetch operand bytes from consecutive addresses
                  next_code_req.req = 1'b1;
                  next_code_req.addr = pc;
                  next_pc = pc + LEN_ONE;
                  next_state = ST_OPND1;
               end else if (code_rsp.data == OP_READ_PTR) begin
                  next_code_req.req = 1'b1;
                  next_code_req.addr = idx_sum(acc, ptr);
                  next_state = ST_TABLE;
               end else if (code_rsp.data == OP_READ_PC) begin
                  // pc already holds the next opcode address
                  next_code_req.req = 1'b1;
                  next_code_req.addr = idx_sum(acc, pc);
                  next_state = ST_TABLE;
               end else if (code_rsp.data == OP_JUMP_IDX) begin
                  next_pc = idx_sum(acc, ptr);
               end else if (code_rsp.data == OP_ROT_LEFT) begin
                  next_acc = {acc[6:0], acc[7]};
               end
            end
         end
         ST_OPND1: begin
            if (code_rsp.valid) begin
               next_opnd1 = code_rsp.data;
               next_state = ST_FETCH;
               if (op_len(opcode) == LEN_THREE) begin
                  next_code_req.req = 1'b1;
                  next_code_req.addr = pc;
                  next_pc = pc + LEN_ONE;
                  next_state = ST_OPND2;
               end else begin
                  // absolute jump inside the current 2k page
                  next_pc = {pc[15:11], opcode[7:5], code_rsp.data};
               end
            end
         end
         ST_OPND2: begin
            if (code_rsp.valid) begin
               next_state = ST_FETCH;
               if (opcode == OP_LONG_JUMP) begin
                  next_pc = {opnd1, code_rsp.data};
               end else if (opcode == OP_PTR_LOAD) begin
                  next_pointer_high_byte = opnd1;
                  next_pointer_low_byte = code_rsp.data;
               end else if (opcode == OP_CMP_BR && acc != opnd1) begin
                  next_pc = pc + {{8{code_rsp.data[7]}}, code_rsp.data};
               end
            end
         end
         ST_TABLE: begin
            if (code_rsp.valid) begin
               next_acc = code_rsp.data;
               next_state = ST_FETCH;
            end
         end
         default: begin
            next_state = ST_FETCH;
         end
      endcase
   end

   // state registers; memory answers one or more cycles after a request
   always_ff @(posedge core_clk or negedge rst_sync) begin
      if (!rst_sync) begin
         state <= ST_FETCH;
         opcode <= 8'h00;
         acc <= ACC_RST;
         pc <= PC_RST;
         pointer_high_byte <= PTR_RST[15:8];
         pointer_low_byte <= PTR_RST[7:0];
         code_req <= '0;
         op_addr <= PC_RST;
         opnd1 <= 8'h00;
      end else begin
         state <= next_state;
         opcode <= next_opcode;
         acc <= next_acc;
         pc <= next_pc;
         pointer_high_byte <= next_pointer_high_byte;
         pointer_low_byte <= next_pointer_low_byte;
         code_req <= next_code_req;
         op_addr <= next_op_addr;
         opnd1 <= next_opnd1;
      end
   end

   // checks
   sequence s_opc(logic [7:0] op);
      state == ST_OPC && code_rsp.valid && code_rsp.data == op;
   endsequence

   a_ptr_read_addr: assert property (
      @(posedge core_clk) disable iff (!rst_sync)
      s_opc(OP_READ_PTR) |=> code_req.req &&
         code_req.addr == $past(acc) + $past(ptr))
      else $error("pointer table read address wrong");

   a_pc_read_addr: assert property (
      @(posedge core_clk) disable iff (!rst_sync)
      s_opc(OP_READ_PC) |=> code_req.addr == $past(acc) + $past(pc))
      else $error("pc table read address wrong");

   a_pc_past_read: assert property (
      @(posedge core_clk) disable iff (!rst_sync)
      s_opc(OP_READ_PC) |-> pc == op_addr + LEN_ONE)
      else $error("pc not past table read");

   a_table_load_acc: assert property (
      @(posedge core_clk) disable iff (!rst_sync)
      state == ST_TABLE && code_rsp.valid |=> acc == $past(code_rsp.data))
      else $error("table byte not in acc");

   a_jump_target: assert property (
      @(posedge core_clk) disable iff (!rst_sync)
      s_opc(OP_JUMP_IDX) |=> pc == $past(acc) + $past(ptr) &&
         $stable(acc) && $stable(ptr) ##1 code_req.addr == $past(pc))
      else $error("computed jump wrong");

   a_rotate_acc: assert property (
      @(posedge core_clk) disable iff (!rst_sync)
      s_opc(OP_ROT_LEFT) |=> acc == {$past(acc[6:0]), $past(acc[7])})
      else $error("rotate left wrong");

   a_return_len: assert property (
      @(posedge core_clk) disable iff (!rst_sync)
      s_opc(OP_RETURN) |=> state == ST_FETCH && pc == op_addr + LEN_ONE)
      else $error("return length not one");

   a_cmp_len: assert property (
      @(posedge core_clk) disable iff (!rst_sync)
      state == ST_OPND2 && code_rsp.valid && opcode == OP_CMP_BR
      && acc == opnd1 |=> pc == op_addr + LEN_THREE)
      else $error("compare length not three");

   a_abs_len: assert property (
      @(posedge core_clk) disable iff (!rst_sync)
      state == ST_OPND1 && code_rsp.valid && op_len(opcode) == LEN_TWO
      |-> pc == op_addr + LEN_TWO)
      else $error("absolute jump length not two");

   a_long_jump_operands: assert property (
      @(posedge core_clk) disable iff (!rst_sync)
      s_opc(OP_LONG_JUMP) |=> code_req.addr == op_addr + LEN_ONE)
      else $error("long jump operand address wrong");
endmodule

/* File: hdl/icr_pkg.sv */
// package for the indexed code read and jump decoder
package icr_pkg;
   // opcodes of the classic core instruction set
   localparam logic [7:0] OP_READ_PTR  = 8'h93; // table read via pointer
   localparam logic [7:0] OP_READ_PC   = 8'h83; // table read via pc
   localparam logic [7:0] OP_JUMP_IDX  = 8'h73; // computed jump
   localparam logic [7:0] OP_ROT_LEFT  = 8'h23; // rotate left acc
   localparam logic [7:0] OP_RETURN    = 8'h22; // subroutine return
   localparam logic [7:0] OP_LONG_JUMP = 8'h02; // long jump
   localparam logic [7:0] OP_CMP_BR    = 8'hb4; // compare acc, branch
   localparam logic [7:0] OP_PTR_LOAD  = 8'h90; // load 16-bit pointer
   localparam logic [4:0] OP_ABS_LOW   = 5'h01; // abs jump low 5 bits
   // encoded lengths in bytes
   localparam logic [15:0] LEN_ONE   = 16'h0001;
   localparam logic [15:0] LEN_TWO   = 16'h0002;
   localparam logic [15:0] LEN_THREE = 16'h0003;
   // reset values
   localparam logic [15:0] PC_RST  = 16'h0000;
   localparam logic [7:0]  ACC_RST = 8'h00;
   localparam logic [15:0] PTR_RST = 16'h0000;
   // code memory request and answer
   typedef struct packed {
      logic        req;
      logic [15:0] addr;
   } icr_code_req_t;
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } icr_code_rsp_t;
   // core state
   typedef enum logic [2:0] {
      ST_FETCH, ST_OPC, ST_OPND1, ST_OPND2, ST_TABLE, ST_STALL
   } icr_state_t;
endpackage

/* File: test/icr_code_mem.sv */
// behavioural code memory answering the core after a random delay
`timescale 1ns/10ps
module icr_code_mem
   import icr_pkg::*;
(
   // clock and reset
   input  wire logic     core_clk,
   input  wire logic     rstn,
   // code memory port
   input  icr_code_req_t code_req,
   output icr_code_rsp_t code_rsp
);
   logic [7:0]  mem [logic [15:0]];
   logic [15:0] seen [$];
   logic [15:0] addr;
   int          wait_n;
   int          seed = 99988;

   // one read in flight; answer after 1 to 3 cycles
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wait_n <= 0;
         // one driver for the answer, cleared with the memory's reset
         code_rsp <= '0;
      end else begin
         code_rsp.valid <= 1'b0;
         // stale byte never looks like an answer
         code_rsp.data <= ~code_rsp.data;
         if (code_req.req) begin
            seen.push_back(code_req.addr);
            addr <= code_req.addr;
            wait_n <= 1 + ({$random(seed)} % 3);
         end else if (wait_n > 0) begin
            wait_n <= wait_n - 1;
            if (wait_n == 1) begin
               code_rsp.valid <= 1'b1;
               // empty locations read as a one-byte no-op
               code_rsp.data <= mem.exists(addr) ? mem[addr] : 8'h00;
            end
         end
      end
   end
endmodule

/* File: test/indexed_code_read_and_jump_tb.sv */
// self-checking bench running small table and jump programs
`timescale 1ns/10ps
module indexed_code_read_and_jump_tb;
   import icr_pkg::*;
   localparam logic [15:0] LJ = 16'h4000;
   logic          core_clk;
   logic          rstn;
   icr_code_req_t code_req;
   icr_code_rsp_t code_rsp;
   logic [7:0]    acc;
   logic [15:0]   pc;
   logic [7:0]    pointer_high_byte;
   logic [7:0]    pointer_low_byte;
   int            errors = 0;
   int            n_checks = 0;
   int            seed = 99988;
   int            cycles = 0;
   logic [15:0]   exp_q [$];
   logic [15:0]   ptr;
   logic [15:0]   tgt;
   logic [15:0]   off;
   logic [7:0]    a;
   logic [7:0]    b;
   logic [7:0]    r;

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   icr_core u_icr_core (
      .core_clk(core_clk), .rstn(rstn), .code_req(code_req),
      .code_rsp(code_rsp), .acc(acc), .pc(pc),
      .pointer_high_byte(pointer_high_byte),
      .pointer_low_byte(pointer_low_byte));
   icr_code_mem u_icr_code_mem (
      .core_clk(core_clk), .rstn(rstn), .code_req(code_req),
      .code_rsp(code_rsp));

   // a hang cuts the run short
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         results();
      end
   end

   function logic [7:0] rol(logic [7:0] v);
      return {v[6:0], v[7]};
   endfunction

   task check16(string what, logic [15:0] exp, logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task put(logic [15:0] ad, logic [7:0] d);
      u_icr_code_mem.mem[ad] = d;
   endtask

   task results;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      rstn = 1'b0;
      for (int it = 0; it < 6; it++) begin
         @(negedge core_clk);
         rstn = 1'b0;
         u_icr_code_mem.mem.delete();
         u_icr_code_mem.seen.delete();
         // corners first: msb wrap on rotate, all ones
         a = (it == 0) ? 8'h80 : (it == 1) ? 8'hff : 8'($random(seed));
         b = 8'($random(seed));
         r = 8'($random(seed));
         if (a == 8'h00) a = 8'h01;
         if (b == 8'h00) b = 8'h01;
         ptr = 16'h2000 + {8'h00, 8'($random(seed))};
         tgt = ptr + {8'h00, b};
         put(0, OP_PTR_LOAD); put(1, ptr[15:8]); put(2, ptr[7:0]);
         put(3, OP_READ_PTR); put(4, OP_ROT_LEFT); put(5, OP_READ_PC);
         put(6, OP_JUMP_IDX); put(ptr, a); put(16'h6 + rol(a), b);
         put(tgt, OP_LONG_JUMP); put(tgt + 1, LJ[15:8]); put(tgt + 2, 8'h00);
         put(LJ, OP_CMP_BR); put(LJ + 1, (it % 2) ? ~b : b);
         // odd tests take the branch over the first page jump
         put(LJ + 2, 8'h02); put(16'h4500 | r, OP_RETURN);
         put(LJ + 3, {3'b101, OP_ABS_LOW}); put(LJ + 4, r);
         put(LJ + 5, {3'b101, OP_ABS_LOW}); put(LJ + 6, r);
         off = (it % 2) ? 16'h0002 : 16'h0000;
         exp_q = '{16'h0, 16'h1, 16'h2, 16'h3, ptr, 16'h4, 16'h5,
                   16'h6 + rol(a), 16'h6, tgt, tgt + 1, tgt + 2, LJ,
                   LJ + 1, LJ + 2, LJ + 3 + off, LJ + 4 + off,
                   16'h4500 | r, (16'h4500 | r) + 16'h1};
         repeat (2) @(negedge core_clk);
         rstn = 1'b1;
         for (int w = 0; w < 400; w++) begin
            if (u_icr_code_mem.seen.size() >= 19) break;
            @(negedge core_clk);
         end
         if (u_icr_code_mem.seen.size() < 19) begin
            errors++;
            $display("[ERR] fetch count expected 19 seen %0d",
                     u_icr_code_mem.seen.size());
         end else begin
            // fetch order shows every address sum and every length
            foreach (exp_q[i])
               check16("fetch addr", exp_q[i],
                       u_icr_code_mem.seen[i]);
         end
         check16("acc", {8'h00, b}, {8'h00, acc});
         check16("pointer", ptr,
                 {pointer_high_byte, pointer_low_byte});
         $display("test %0d done", it);
      end
      results();
   end
endmodule
